// [rtl/faar_pkg.sv]
// constants and state type of the fiber advertisement register bank
package faar_pkg;
	// ========================================================================
	// register byte addresses
	localparam logic [3:0] ADDR_CTRL   = 4'h0;
	localparam logic [3:0] ADDR_ADVERT = 4'h4;
	localparam logic [3:0] ADDR_CFG    = 4'h8;
	localparam logic [3:0] ADDR_ACTIVE = 4'hc;

	// ========================================================================
	// fiber mode field values
	localparam logic [1:0] MODE_1000X = 2'h1;
	localparam logic [1:0] MODE_SGMII = 2'h2;

	// ========================================================================
	// control and config bit positions
	localparam int CTRL_SW_RST  = 15;
	localparam int CTRL_PWR_DN  = 11;
	localparam int CTRL_RESTART = 9;
	localparam int CFG_RPT_EN   = 7;

	// ========================================================================
	// 1000x layout fields
	localparam int ADV_NP      = 15;
	localparam int ADV_RF_HI   = 13;
	localparam int ADV_RF_LO   = 12;
	localparam int ADV_PAUSE_HI = 8;
	localparam int ADV_PAUSE_LO = 7;
	localparam int ADV_HD      = 6;
	localparam logic [15:0] ADV_WMASK  = 16'hb1ff;
	localparam logic [15:0] ADV_HW_RST = 16'h0020;
	localparam logic [15:0] ADV_SW_CLR = 16'hffe0;

	// ========================================================================
	// sgmii system layout constants
	localparam logic [6:0] SGMII_LOW = 7'h01;
	localparam logic [1:0] SGMII_RSV = 2'h0;

	// ========================================================================
	// start-up strap capture
	localparam logic [1:0] BOOT_LOAD = 2'h2;
	localparam logic [1:0] BOOT_DONE = 2'h3;

	typedef struct packed {
		logic [15:0] shadow;
		logic [15:0] active;
		logic [1:0]  mode;
		logic        rpt_en;
		logic        pwr_dn;
		logic        link_prev;
		logic [1:0]  pause_s;
		logic [1:0]  hd_s;
		logic [1:0]  boot;
		logic        ack;
		logic [31:0] rdata;
	} faar_state_t;
endpackage

// [rtl/faar_advert.sv]
// fiber auto-negotiation advertisement register bank with avalon-mm slave
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - The two-bit mode field picks the layout: 01 writable 1000BASE-X, 10 read-only SGMII status.
// - In 1000BASE-X mode writes are stored at once while negotiation keeps the old value.
// - The stored value takes effect on software reset, restart, leaving power down or link loss.
// - Bits 13:12 hold the remote-fault code 00..11 and reset to 00.
// - The remote-fault field carries only what software writes.
// - Hardware reset loads both pause bits 8:7 from the pause-enable strap.
// - Pause code 00 none, 01 symmetric, 10 asymmetric to partner, 11 both.
// - Hardware reset loads half-duplex bit 6 from negotiation strap bit 0.
// - In SGMII mode bit 15 reads the copper link state.
// - In SGMII mode bit 12 reads the resolved duplex, 1 for full.
// - In SGMII mode bits 11:10 read the resolved speed code.
// - In SGMII mode bits 9, 8 and 7 read 0 while the report enable bit is clear.
// - In SGMII mode bit 7 reads the media type, 1 for fiber.
module faar_advert (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	// avalon-mm slave
	input  wire logic [3:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output logic [31:0]      readdata,
	output logic             waitrequest,
	// strap pins
	input  wire logic        pause_enable_strap,
	input  wire logic        negotiation_config_strap_bit0,
	// fiber link and copper status from on-chip logic
	input  wire logic        fiber_link_up,
	input  wire logic        copper_link_up,
	input  wire logic        copper_full_duplex,
	input  wire logic [1:0]  copper_speed,
	input  wire logic        copper_tx_pause,
	input  wire logic        copper_rx_pause,
	input  wire logic        media_is_fiber,
	// negotiation engine side
	output logic [15:0]      adv_word,
	output logic [1:0]       fiber_mode
);
	faar_pkg::faar_state_t st_q;
	faar_pkg::faar_state_t st_d;

	logic        req;
	logic        acc;
	logic        wr_ctrl;
	logic        wr_adv;
	logic        sw_rst;
	logic        trig;
	logic        boot_done;
	logic [15:0] wmask;
	logic [15:0] rd_word;
	logic [15:0] sgmii_word;
	logic [15:0] adv_wr_val;

	// ========================================================================
	// bus handshake: one wait cycle, then the transfer completes
	assign req         = read | write;
	assign boot_done   = (st_q.boot == faar_pkg::BOOT_DONE);
	assign waitrequest = req & ~st_q.ack;
	assign acc         = req & st_q.ack;
	assign readdata    = st_q.rdata;
	assign adv_word    = st_q.active;
	assign fiber_mode  = st_q.mode;

	// byte lane mask for the 16-bit registers
	assign wmask = {{8{byteenable[1]}}, {8{byteenable[0]}}};

	// write decode
	assign wr_ctrl = acc & write & (address == faar_pkg::ADDR_CTRL);
	assign wr_adv  = acc & write & (address == faar_pkg::ADDR_ADVERT)
		& (st_q.mode == faar_pkg::MODE_1000X);
	assign sw_rst  = wr_ctrl & byteenable[1] & writedata[faar_pkg::CTRL_SW_RST];

	// ========================================================================
	// events that hand the shadow over to the negotiation engine
	always_comb begin
		trig = sw_rst;
		if (wr_ctrl && byteenable[1] && writedata[faar_pkg::CTRL_RESTART]) begin
			trig = 1'b1;
		end
		if (wr_ctrl && byteenable[1] && st_q.pwr_dn && !writedata[faar_pkg::CTRL_PWR_DN]) begin
			trig = 1'b1;
		end
		if (st_q.link_prev && !fiber_link_up) begin
			trig = 1'b1;
		end
	end

	// new shadow on an advert write, only writable bits, rf from software only
	assign adv_wr_val = (st_q.shadow & ~(wmask & faar_pkg::ADV_WMASK))
		| (writedata[15:0] & wmask & faar_pkg::ADV_WMASK);

	// sgmii system status view
	always_comb begin
		sgmii_word = '0;
		sgmii_word[15]    = copper_link_up;
		sgmii_word[14:13] = faar_pkg::SGMII_RSV;
		sgmii_word[12]    = copper_full_duplex;
		sgmii_word[11:10] = copper_speed;
		sgmii_word[9]     = copper_tx_pause & st_q.rpt_en;
		sgmii_word[8]     = copper_rx_pause & st_q.rpt_en;
		sgmii_word[7]     = media_is_fiber & st_q.rpt_en;
		sgmii_word[6:0]   = faar_pkg::SGMII_LOW;
	end

	// ========================================================================
	// read mux
	always_comb begin
		rd_word = '0;
		unique case (address)
			faar_pkg::ADDR_CTRL: begin
				rd_word[faar_pkg::CTRL_PWR_DN] = st_q.pwr_dn;
			end
			faar_pkg::ADDR_ADVERT: begin
				if (st_q.mode == faar_pkg::MODE_1000X) begin
					rd_word = st_q.shadow;
				end else if (st_q.mode == faar_pkg::MODE_SGMII) begin
					rd_word = sgmii_word;
				end
			end
			faar_pkg::ADDR_CFG: begin
				rd_word[1:0] = st_q.mode;
				rd_word[faar_pkg::CFG_RPT_EN] = st_q.rpt_en;
			end
			faar_pkg::ADDR_ACTIVE: begin
				rd_word = st_q.active;
			end
			default: begin
				rd_word = '0;
			end
		endcase
	end

	// ========================================================================
	// next state
	always_comb begin
		st_d = st_q;
		// strap synchronisers, first stage feeds only the second
		st_d.pause_s = {st_q.pause_s[0], pause_enable_strap};
		st_d.hd_s    = {st_q.hd_s[0], negotiation_config_strap_bit0};
		st_d.link_prev = fiber_link_up;
		if (!boot_done) begin
			st_d.boot = st_q.boot + 2'h1;
		end
		// strap values replace the hardware reset constants once settled
		if (st_q.boot == faar_pkg::BOOT_LOAD) begin
			st_d.shadow[faar_pkg::ADV_PAUSE_HI:faar_pkg::ADV_PAUSE_LO] =
				{2{st_q.pause_s[1]}};
			st_d.shadow[faar_pkg::ADV_HD] = st_q.hd_s[1];
			st_d.active[faar_pkg::ADV_PAUSE_HI:faar_pkg::ADV_PAUSE_LO] =
				{2{st_q.pause_s[1]}};
			st_d.active[faar_pkg::ADV_HD] = st_q.hd_s[1];
		end
		// one wait cycle per request, held off until straps are loaded
		st_d.ack = req & ~st_q.ack & boot_done;
		if (req && !st_q.ack) begin
			st_d.rdata = {16'h0000, rd_word};
		end
		// register writes
		if (wr_ctrl && byteenable[1]) begin
			st_d.pwr_dn = writedata[faar_pkg::CTRL_PWR_DN];
		end
		if (acc && write && address == faar_pkg::ADDR_CFG && byteenable[0]) begin
			st_d.mode   = writedata[1:0];
			st_d.rpt_en = writedata[faar_pkg::CFG_RPT_EN];
		end
		if (wr_adv) begin
			st_d.shadow = adv_wr_val;
		end
		// software reset clears the low reserved field, shadow otherwise kept
		if (sw_rst) begin
			st_d.shadow = st_q.shadow & faar_pkg::ADV_SW_CLR;
		end
		if (trig) begin
			st_d.active = st_d.shadow;
		end
	end

	// ========================================================================
	// state register
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			st_q        <= '0;
			st_q.shadow <= faar_pkg::ADV_HW_RST;
			st_q.active <= faar_pkg::ADV_HW_RST;
			st_q.mode   <= faar_pkg::MODE_1000X;
		end else begin
			st_q <= st_d;
		end
	end

	// ========================================================================
	// checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	sequence s_adv_read_sgmii;
		read && !waitrequest && address == faar_pkg::ADDR_ADVERT
			&& st_q.mode == faar_pkg::MODE_SGMII && $stable(st_q.mode);
	endsequence

	sequence s_adv_write;
		write && !waitrequest && address == faar_pkg::ADDR_ADVERT
			&& st_q.mode == faar_pkg::MODE_1000X && byteenable[1:0] == 2'h3;
	endsequence

	a_bus_answer_one: assert property (req && waitrequest && boot_done && !st_q.ack
		|=> !waitrequest) else $error("request not answered after one wait cycle");

	a_sgmii_fixed_bits: assert property (s_adv_read_sgmii
		|-> readdata[6:0] == 7'h01 && readdata[14:13] == 2'h0)
		else $error("sgmii reserved bits wrong");

	a_sgmii_link_bit: assert property (s_adv_read_sgmii
		|-> readdata[15] == $past(copper_link_up) && readdata[12] == $past(copper_full_duplex))
		else $error("sgmii link or duplex bit wrong");

	a_sgmii_gate_bits: assert property ((s_adv_read_sgmii and !st_q.rpt_en)
		|-> readdata[9:7] == 3'h0) else $error("gated sgmii bits not zero");

	a_adv_write_stored: assert property (s_adv_write
		|=> st_q.shadow == ($past(writedata[15:0]) & faar_pkg::ADV_WMASK))
		else $error("advert write not stored");

	a_active_held: assert property (boot_done && !trig
		|=> $stable(adv_word)) else $error("active advert changed without trigger");

	a_link_loss_load: assert property (boot_done && st_q.link_prev && !fiber_link_up
		&& !wr_adv && !sw_rst |=> adv_word == $past(st_q.shadow))
		else $error("link loss did not load shadow");

	a_rf_sw_only: assert property (!wr_adv
		|=> $stable(st_q.shadow[13:12])) else $error("remote fault changed without write");

	a_strap_loaded: assert property (st_q.boot == faar_pkg::BOOT_LOAD
		|=> adv_word[8:7] == {2{$past(st_q.pause_s[1])}}
		&& adv_word[6] == $past(st_q.hd_s[1])) else $error("straps not loaded");

	a_sw_rst_keep: assert property (sw_rst
		|=> st_q.shadow[15:5] == $past(st_q.shadow[15:5]) && adv_word == st_q.shadow)
		else $error("software reset lost shadow");

	// restart bit written through the control register
	sequence s_restart_write;
		wr_ctrl && byteenable[1] && writedata[faar_pkg::CTRL_RESTART];
	endsequence

	// power down left by a control write
	sequence s_power_up_write;
		wr_ctrl && byteenable[1] && st_q.pwr_dn && !writedata[faar_pkg::CTRL_PWR_DN];
	endsequence

	// advert read taken while the mode sits at 00 or 11
	sequence s_adv_read_idle_mode;
		read && !waitrequest && address == faar_pkg::ADDR_ADVERT
			&& st_q.mode[0] == st_q.mode[1] && $stable(st_q.mode);
	endsequence

	// restart hands the shadow over at the next edge
	a_restart_load: assert property ((s_restart_write and !sw_rst)
		|=> adv_word == st_q.shadow) else $error("restart did not load shadow");

	// leaving power down hands the shadow over
	a_power_up_load: assert property ((s_power_up_write and !sw_rst)
		|=> adv_word == st_q.shadow) else $error("power up did not load shadow");

	// software reset clears the low reserved field of the active word too
	a_sw_rst_trigger: assert property (sw_rst
		|=> adv_word[4:0] == 5'h00) else $error("software reset left low field set");

	// modes without a layout read as zero
	a_idle_mode_zero: assert property (s_adv_read_idle_mode
		|-> readdata == 32'h0000_0000) else $error("advert read not zero in idle mode");

	// the 1000x view shows the shadow
	a_1000x_view: assert property (read && !waitrequest && address == faar_pkg::ADDR_ADVERT
		&& st_q.mode == faar_pkg::MODE_1000X && $stable(st_q.mode) && $stable(st_q.shadow)
		|-> readdata[15:0] == st_q.shadow) else $error("1000x view not the shadow");

	// writes to the advert address are dropped outside 1000x mode
	a_advert_locked: assert property (boot_done && write && !waitrequest
		&& address == faar_pkg::ADDR_ADVERT && st_q.mode != faar_pkg::MODE_1000X
		|=> $stable(st_q.shadow)) else $error("advert written outside 1000x mode");

	// the upper half of the data bus never carries anything
	a_upper_read_zero: assert property (read && !waitrequest
		|-> readdata[31:16] == 16'h0000) else $error("upper read half not zero");

	// the mode field reads back as stored
	a_cfg_read_back: assert property (read && !waitrequest && address == faar_pkg::ADDR_CFG
		&& $stable(st_q.mode) |-> readdata[1:0] == st_q.mode) else $error("mode read back wrong");

	// speed code passes straight through
	a_sgmii_speed_bits: assert property (s_adv_read_sgmii
		|-> readdata[11:10] == $past(copper_speed)) else $error("sgmii speed bits wrong");

	// media bit follows the status when reporting is enabled
	a_sgmii_media_bit: assert property ((s_adv_read_sgmii and st_q.rpt_en)
		|-> readdata[7] == $past(media_is_fiber)) else $error("sgmii media bit wrong");

	// pause bits follow the status when reporting is enabled
	a_sgmii_pause_bits: assert property ((s_adv_read_sgmii and st_q.rpt_en)
		|-> readdata[9:8] == {$past(copper_tx_pause), $past(copper_rx_pause)})
		else $error("sgmii pause bits wrong");

	// reserved bits 14 and 11:9 of the shadow never get set
	a_rsv_bits_clear: assert property (boot_done
		|-> st_q.shadow[14] == 1'b0 && st_q.shadow[11:9] == 3'h0)
		else $error("reserved advert bit set");

	// remote fault lands exactly as written
	a_rf_write_path: assert property (s_adv_write
		|=> st_q.shadow[13:12] == $past(writedata[13:12])) else $error("remote fault not stored");

	// pause code lands exactly as written
	a_pause_write_path: assert property (s_adv_write
		|=> st_q.shadow[8:7] == $past(writedata[8:7])) else $error("pause code not stored");

	// half duplex bit lands exactly as written
	a_hd_write_path: assert property (s_adv_write
		|=> st_q.shadow[6] == $past(writedata[6])) else $error("half duplex bit not stored");

	// requests stall until the straps are in
	a_boot_stall: assert property (req && !boot_done
		|-> waitrequest) else $error("request answered before straps loaded");
endmodule

`default_nettype wire

// [tb/faar_peer.sv]
// far-side model: fiber link partner and copper status source
`timescale 1ns/1ps
`default_nettype none
module faar_peer (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       resetn,
	// commands from the bench
	input  wire logic       drop_req,
	input  wire logic [6:0] status,
	// levels seen by the block
	output logic            fiber_link_up,
	output logic            copper_link_up,
	output logic            copper_full_duplex,
	output logic [1:0]      copper_speed,
	output logic            copper_tx_pause,
	output logic            copper_rx_pause,
	output logic            media_is_fiber
);
	// link falls for one cycle per drop request; copper status follows the bench
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			fiber_link_up <= 1'b1;
			{copper_link_up, copper_full_duplex, copper_speed} <= 4'h0;
			{copper_tx_pause, copper_rx_pause, media_is_fiber} <= 3'h0;
		end else begin
			fiber_link_up <= !drop_req;
			{copper_link_up, copper_full_duplex, copper_speed} <= status[6:3];
			{copper_tx_pause, copper_rx_pause, media_is_fiber} <= status[2:0];
		end
	end
endmodule
`default_nettype wire

// [tb/faar_advert_test.sv]
// self-checking bench of the fiber advertisement register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
	$display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module faar_advert_test;
	logic        clk_sys, resetn, read, write, drop_req, fl, cl, cd, ct, cr, mf;
	logic [3:0]  address, byteenable;
	logic [31:0] writedata, readdata;
	logic        waitrequest, ps, hs;
	logic [15:0] adv_word;
	logic [1:0]  fiber_mode, cs;
	logic [6:0]  status;
	int          bad_count, comparisons, cycles;

	faar_advert uut (.clk_sys(clk_sys), .resetn(resetn), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .pause_enable_strap(ps),
		.negotiation_config_strap_bit0(hs), .fiber_link_up(fl), .copper_link_up(cl),
		.copper_full_duplex(cd), .copper_speed(cs), .copper_tx_pause(ct),
		.copper_rx_pause(cr), .media_is_fiber(mf), .adv_word(adv_word),
		.fiber_mode(fiber_mode));
	faar_peer peer (.clk_sys(clk_sys), .resetn(resetn), .drop_req(drop_req), .status(status),
		.fiber_link_up(fl), .copper_link_up(cl), .copper_full_duplex(cd), .copper_speed(cs),
		.copper_tx_pause(ct), .copper_rx_pause(cr), .media_is_fiber(mf));

	// ========================================================================
	// clock and hang guard
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			bad_count++;
			end_of_test();
		end
	end

	// ========================================================================
	// bus transfer: hold until waitrequest seen low, take data at that edge
	task automatic bus(input logic [3:0] a, input logic wr, input logic [15:0] d,
		output logic [31:0] rd);
		@(posedge clk_sys);
		address <= a;
		read <= !wr;
		write <= wr;
		writedata <= {16'h0000, d};
		do @(posedge clk_sys); while (waitrequest !== 1'b0);
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		logic [31:0] v;
		bus(a, 1'b1, d, v);
	endtask
	task automatic rchk(input logic [3:0] a, input logic [31:0] e);
		logic [31:0] v;
		bus(a, 1'b0, 16'h0000, v);
		`CHK(v, e)
	endtask
	task automatic drop_link;
		@(posedge clk_sys);
		drop_req <= 1'b1;
		@(posedge clk_sys);
		drop_req <= 1'b0;
	endtask

	// ========================================================================
	// scenarios
	task automatic t_reset;
		rchk(faar_pkg::ADDR_ADVERT, 32'h01a0);
		`CHK(adv_word, 16'h01a0)
		rchk(faar_pkg::ADDR_CFG, 32'h0001);
		rchk(4'h2, 32'h0000);
	endtask
	task automatic t_defer;
		wr(faar_pkg::ADDR_ADVERT, 16'hffff);
		rchk(faar_pkg::ADDR_ADVERT, 32'hb1ff);
		rchk(faar_pkg::ADDR_ACTIVE, 32'h01a0);
		wr(faar_pkg::ADDR_CTRL, 16'h0200);
		rchk(faar_pkg::ADDR_ACTIVE, 32'hb1ff);
	endtask
	task automatic t_codes;
		logic [15:0] e;
		for (int i = 0; i < 4; i++) begin
			e = {2'b00, i[1:0], 3'b000, i[1:0], 7'h20};
			wr(faar_pkg::ADDR_ADVERT, e);
			drop_link();
			rchk(faar_pkg::ADDR_ACTIVE, {16'h0000, e});
		end
	endtask
	task automatic t_power;
		wr(faar_pkg::ADDR_CTRL, 16'h0800);
		wr(faar_pkg::ADDR_ADVERT, 16'h0040);
		rchk(faar_pkg::ADDR_CTRL, 32'h0800);
		rchk(faar_pkg::ADDR_ACTIVE, 32'h31a0);
		wr(faar_pkg::ADDR_CTRL, 16'h0000);
		rchk(faar_pkg::ADDR_ACTIVE, 32'h0040);
	endtask
	task automatic t_swrst;
		wr(faar_pkg::ADDR_ADVERT, 16'h801f);
		wr(faar_pkg::ADDR_CTRL, 16'h8000);
		rchk(faar_pkg::ADDR_ADVERT, 32'h8000);
		rchk(faar_pkg::ADDR_ACTIVE, 32'h8000);
		`CHK(adv_word, 16'h8000)
	endtask
	task automatic t_sgmii;
		status <= 7'h7f;
		wr(faar_pkg::ADDR_CFG, 16'h0002);
		rchk(faar_pkg::ADDR_ADVERT, 32'h9c01);
		wr(faar_pkg::ADDR_CFG, 16'h0082);
		for (int k = 0; k < 3; k++) begin
			status <= {k[0], k[1], k[1:0], k[0], k[1], k[0]};
			rchk(faar_pkg::ADDR_ADVERT, {16'h0, k[0], 2'b00, k[1], k[1:0], k[0], k[1], k[0],
				7'h01});
		end
		wr(faar_pkg::ADDR_ADVERT, 16'h0000);
		wr(faar_pkg::ADDR_CFG, 16'h0003);
		rchk(faar_pkg::ADDR_ADVERT, 32'h0000);
		wr(faar_pkg::ADDR_CFG, 16'h0001);
		rchk(faar_pkg::ADDR_ADVERT, 32'h8000);
		`CHK(fiber_mode, faar_pkg::MODE_1000X)
	endtask
	task automatic t_straps;
		@(posedge clk_sys);
		ps <= 1'b0;
		hs <= 1'b1;
		resetn <= 1'b0;
		repeat (2) @(posedge clk_sys);
		resetn <= 1'b1;
		repeat (4) @(posedge clk_sys);
		rchk(faar_pkg::ADDR_ADVERT, 32'h0060);
		rchk(faar_pkg::ADDR_CFG, 32'h0001);
	endtask

	// ========================================================================
	// verdict and main sequence
	task automatic end_of_test;
		$display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		resetn = 1'b0;
		{read, write, drop_req, address, writedata} = '0;
		byteenable = 4'hf;
		status = 7'h00;
		ps = 1'b1;
		hs = 1'b0;
		repeat (2) @(posedge clk_sys);
		resetn <= 1'b1;
		repeat (4) @(posedge clk_sys);
		t_reset();
		t_defer();
		t_codes();
		t_power();
		t_swrst();
		t_sgmii();
		t_straps();
		end_of_test();
	end
endmodule
`default_nettype wire
